// [hw/aom_pkg.sv]
// constants of the analog output module register map
package aom_pkg;
	// coil and discrete-input references
	localparam logic [15:0] A_OPEN_WIRE   = 16'h00E1;
	localparam logic [15:0] A_OPEN_WIRE_D = 16'h27F1;
	localparam logic [15:0] A_PROTO       = 16'h0101;
	localparam logic [15:0] A_WDT_MODE    = 16'h0104;
	localparam logic [15:0] A_WDT_EN      = 16'h0105;
	localparam logic [15:0] A_FORMAT      = 16'h010D;
	localparam logic [15:0] A_WDT_FLAG    = 16'h010E;
	localparam logic [15:0] A_CAL_RELOAD  = 16'h0110;
	localparam logic [15:0] A_FIRST_READ  = 16'h0111;
	// input and holding references
	localparam logic [15:0] A_READBACK_I  = 16'h7571;
	localparam logic [15:0] A_READBACK_H  = 16'h9C81;
	localparam logic [15:0] A_OUT_VALUE   = 16'h9C41;
	localparam logic [15:0] A_SAFE_VALUE  = 16'h9CA1;
	localparam logic [15:0] A_PWR_VALUE   = 16'h9D01;
	localparam logic [15:0] A_TYPE_CODE   = 16'h9D41;
	localparam logic [15:0] A_SLEW        = 16'h9D61;
	localparam logic [15:0] A_FW_LO       = 16'h9E21;
	localparam logic [15:0] A_FW_HI       = 16'h9E22;
	localparam logic [15:0] A_MODEL_LO    = 16'h9E23;
	localparam logic [15:0] A_MODEL_HI    = 16'h9E24;
	localparam logic [15:0] A_NODE_ADDR   = 16'h9E25;
	localparam logic [15:0] A_LINE        = 16'h9E26;
	localparam logic [15:0] A_REPLY_DELAY = 16'h9E28;
	localparam logic [15:0] A_WDT_SET     = 16'h9E29;
	localparam logic [15:0] A_WDT_COUNT   = 16'h9E2C;
	// line settings fields
	localparam int          BAUD_LSB      = 0;
	localparam int          BAUD_W        = 6;
	localparam int          FRAME_LSB     = 6;
	localparam logic [5:0]  BAUD_MIN      = 6'h03;
	localparam logic [5:0]  BAUD_MAX      = 6'h0A;
	localparam logic [5:0]  BAUD_9600     = 6'h06;
	localparam logic [1:0]  FRAME_N1      = 2'h0;
	// limits and reset values
	localparam logic [15:0] DELAY_MAX     = 16'h001E;
	localparam logic [15:0] WDT_SET_MAX   = 16'h00FF;
	localparam logic [15:0] NODE_RST      = 16'h0001;
	localparam logic [7:0]  NODE_RECOVERY = 8'h00;
	localparam logic [15:0] LINE_RST      = 16'h0006;
	localparam logic        PROTO_RST     = 1'b1;
	localparam logic [1:0]  INIT_WAIT     = 2'h3;
	// identity words: values are arbitrary
	localparam logic [15:0] FW_LO_ID      = 16'h0001;
	localparam logic [15:0] FW_HI_ID      = 16'h0000;
	localparam logic [15:0] MODEL_LO_ID   = 16'h0ABC;
	localparam logic [15:0] MODEL_HI_ID   = 16'h0123;
	// timing
	localparam int          CLK_HZ        = 20_000_000;
	localparam int          MS_PER_S      = 1000;
	localparam int          WDT_UNIT_MS   = 100;
	localparam int          MS_CYC        = CLK_HZ / MS_PER_S;
	localparam int          WDT_TICK_CYC  = MS_CYC * WDT_UNIT_MS;
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_WAIT = 1'b1
	} aom_state_t;
endpackage : aom_pkg

// [hw/aom_regs.sv]
// register map and host watchdog of the eight-channel analog output module
// Functional notes
// RL1 - readback per channel in input and holding ranges
// RL2 - eight read-write output value registers
// RL3 - line settings: baud bits 5:0, framing 7:6
// RL4 - reply delay 0..30 ms before answering
// RL5 - watchdog timeout 0..255 tenths of second
// RL6 - timeout count readable, writing 0 clears
// RL7 - protocol coil: 0 ascii, 1 modbus
// RL8 - mode 1: output writes clear timeout
// RL9 - watchdog enable coil turns supervision on
// RL10 - format coil: 0 hex, 1 engineering
// RL11 - timeout status coil, write 1 clears
// RL12 - write 1 reloads factory calibration
// RL13 - reset coil reads 1 once after reset
// RL14 - open-wire bits in coil and discrete ranges
// RL15 - bipolar hex codes are two's complement
// RL16 - 4-20 mA engineering range 4000..20000
// RL17 - indicator off on command, on after reply
// RL18 - recovery mode: address 0, 9600, ascii
// RL19 - timeout sets flag, loads safe values
// RL20 - output writes ignored while timed out
// RL21 - power-on loads power-on or safe values
// RL22 - each timeout increments count, saturating
// RL23 - host must poll faster than timeout
`timescale 1ns/100ps
`default_nettype none
module aom_regs
	import aom_pkg::*;
#(
	parameter int NUM_CH   = 8,
	parameter int MS_CYCLES  = MS_CYC,
	parameter int WDT_CYCLES = WDT_TICK_CYC
) (
	input  wire logic               I_CLK_SYS,
	input  wire logic               I_RST,
	input  wire logic               I_REQ_RD,
	input  wire logic               I_REQ_WR,
	input  wire logic [15:0]        I_REQ_ADDR,
	input  wire logic [15:0]        I_REQ_WDATA,
	input  wire logic               I_RECOVERY,
	input  wire logic [NUM_CH-1:0]  I_OPEN_WIRE,
	input  wire logic               I_WDT_FLAG_NV,
	output logic                    O_RSP_VALID,
	output logic [15:0]             O_RSP_RDATA,
	output logic                    O_RSP_ERR,
	output logic                    O_BUSY,
	output logic [NUM_CH*16-1:0]    O_AO_VALUE,
	output logic                    O_WDT_FLAG,
	output logic                    O_CAL_RELOAD,
	output logic                    O_PWR_LED,
	output logic                    O_PROTO_MODBUS,
	output logic [7:0]              O_NODE_ADDR,
	output logic [5:0]              O_BAUD_CODE,
	output logic [1:0]              O_FRAMING,
	output logic                    O_FORMAT_ENG
);
	if (NUM_CH < 1 || NUM_CH > 8 || MS_CYCLES < 1 || WDT_CYCLES < 1) begin : g_bad_param
		$error("aom_regs: unsupported parameter value");
	end

	// ----------------------------------------
	// decoding helpers
	// ----------------------------------------
	function automatic logic ch_hit(input logic [15:0] a, input logic [15:0] base);
		logic [15:0] d;
		d = a - base;
		ch_hit = (a >= base) && (d < 16'(NUM_CH));
	endfunction : ch_hit

	// engineering limits per type code; hex values pass unchanged
	function automatic logic [15:0] clamp_eng(input logic [15:0] v, input logic [15:0] t);
		logic signed [15:0] lo;
		logic signed [15:0] hi;
		lo = 16'sh0000;
		hi = 16'sh4E20;
		unique case (t)
			16'h0001: lo = 16'sh0FA0; // [RL16]
			16'h0002: hi = 16'sh2710;
			16'h0003: begin
				lo = -16'sh2710;
				hi = 16'sh2710;
			end
			16'h0004: hi = 16'sh1388;
			16'h0005: begin
				lo = -16'sh1388;
				hi = 16'sh1388;
			end
			default: lo = 16'sh0000;
		endcase
		if ($signed(v) < lo)
			clamp_eng = lo;
		else if ($signed(v) > hi)
			clamp_eng = hi;
		else
			clamp_eng = v;
	endfunction : clamp_eng

	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [15:0]       ao [NUM_CH];
	logic [15:0]       safe_v [NUM_CH];
	logic [15:0]       pwr_v [NUM_CH];
	logic [15:0]       type_c [NUM_CH];
	logic [15:0]       slew [NUM_CH];
	logic [15:0]       node_addr;
	logic [15:0]       line_set;
	logic [15:0]       reply_delay;
	logic [15:0]       wdt_set;
	logic [15:0]       wdt_count;
	logic              proto;
	logic              wdt_mode;
	logic              wdt_en;
	logic              fmt_eng;
	logic              wdt_flag;
	logic              first_read;
	logic [NUM_CH-1:0] ow_s1;
	logic [NUM_CH-1:0] ow_s2;
	logic [NUM_CH-1:0] ow_s3;
	logic [NUM_CH-1:0] open_wire;
	logic [2:0]        rec_s;
	logic              recovery;
	logic [1:0]        init_cnt;
	logic              init_done;
	logic              init_load;
	aom_state_t        state;

	// ----------------------------------------
	// request acceptance
	// ----------------------------------------
	logic              take;
	logic              wr_take;
	logic              rd_take;
	logic [15:0]       a;
	logic [2:0]        ch;
	logic [15:0]       wd;
	logic              ao_write;

	// busy still stands in the answer's cycle, so a request held until the answer is not taken twice
	assign take     = (I_REQ_RD | I_REQ_WR) && !O_BUSY && state == ST_IDLE && init_done;
	assign wr_take  = take & I_REQ_WR;
	assign rd_take  = take & ~I_REQ_WR;
	assign a        = I_REQ_ADDR;
	assign wd       = I_REQ_WDATA;
	assign ch       = I_REQ_ADDR[2:0] - A_OUT_VALUE[2:0];
	assign ao_write = wr_take && ch_hit(a, A_OUT_VALUE);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			ow_s1     <= '0;
			ow_s2     <= '0;
			ow_s3     <= '0;
			open_wire <= '0;
			rec_s     <= 3'h0;
			recovery  <= 1'b0;
		end else begin
			ow_s1 <= I_OPEN_WIRE;
			ow_s2 <= ow_s1;
			ow_s3 <= ow_s2;
			for (int i = 0; i < NUM_CH; i++) begin
				if (ow_s2[i] == ow_s3[i])
					open_wire[i] <= ow_s2[i];
			end
			rec_s <= {rec_s[1:0], I_RECOVERY};
			if (rec_s[1] == rec_s[2])
				recovery <= rec_s[1];
		end
	end

	// ----------------------------------------
	// start-up: wait for pins to settle, then load outputs
	// ----------------------------------------
	assign init_load = !init_done && init_cnt == INIT_WAIT;

	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			init_cnt  <= 2'h0;
			init_done <= 1'b0;
		end else if (!init_done) begin
			init_cnt <= init_cnt + 2'h1;
			if (init_cnt == INIT_WAIT)
				init_done <= 1'b1;
		end
	end

	// ----------------------------------------
	// host watchdog
	// ----------------------------------------
	logic [31:0] tick_div;
	logic        tick;
	logic [7:0]  idle_ticks;
	logic        wdt_event;

	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			tick_div <= 32'h0;
			tick     <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (tick_div == 32'(WDT_CYCLES - 1)) begin
				tick_div <= 32'h0;
				tick     <= 1'b1; // [RL5]
			end else begin
				tick_div <= tick_div + 32'h1;
			end
		end
	end

	// any served request restarts the idle time of the host
	assign wdt_event = wdt_en && !wdt_flag && init_done && tick && !take
		&& wdt_set[7:0] != 8'h00 && idle_ticks + 8'h01 == wdt_set[7:0]; // [RL9] [RL23]

	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST)
			idle_ticks <= 8'h00;
		else if (take || !wdt_en || wdt_flag)
			idle_ticks <= 8'h00;
		else if (tick && idle_ticks != 8'hFF)
			idle_ticks <= idle_ticks + 8'h01;
	end

	// set wins over every clear
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST)
			wdt_flag <= 1'b0;
		else if (init_load)
			wdt_flag <= I_WDT_FLAG_NV;
		else if (wdt_event)
			wdt_flag <= 1'b1; // [RL19]
		else if (wr_take && a == A_WDT_FLAG && wd[0])
			wdt_flag <= 1'b0; // [RL11]
		else if (ao_write && wdt_mode)
			wdt_flag <= 1'b0; // [RL8]
	end

	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST)
			wdt_count <= 16'h0000;
		else if (wdt_event) begin
			if (wdt_count != 16'hFFFF)
				wdt_count <= wdt_count + 16'h0001; // [RL22]
		end else if (wr_take && a == A_WDT_COUNT && wd == 16'h0000)
			wdt_count <= 16'h0000; // [RL6]
	end

	// ----------------------------------------
	// analog output values
	// ----------------------------------------
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			for (int i = 0; i < NUM_CH; i++)
				ao[i] <= 16'h0000;
		end else if (init_load) begin
			for (int i = 0; i < NUM_CH; i++)
				ao[i] <= I_WDT_FLAG_NV ? safe_v[i] : pwr_v[i]; // [RL21]
		end else if (wdt_event) begin
			for (int i = 0; i < NUM_CH; i++)
				ao[i] <= safe_v[i]; // [RL19]
		end else if (ao_write && !wdt_flag) begin // [RL20]
			ao[ch] <= fmt_eng ? clamp_eng(wd, type_c[ch]) : wd; // [RL2] [RL10] [RL15]
		end
	end

	// ----------------------------------------
	// per-channel settings
	// ----------------------------------------
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			for (int i = 0; i < NUM_CH; i++) begin
				safe_v[i] <= 16'h0000;
				pwr_v[i]  <= 16'h0000;
				type_c[i] <= 16'h0000;
				slew[i]   <= 16'h0000;
			end
		end else if (wr_take) begin
			if (ch_hit(a, A_SAFE_VALUE))
				safe_v[a[2:0] - A_SAFE_VALUE[2:0]] <= wd;
			if (ch_hit(a, A_PWR_VALUE))
				pwr_v[a[2:0] - A_PWR_VALUE[2:0]] <= wd;
			if (ch_hit(a, A_TYPE_CODE))
				type_c[a[2:0] - A_TYPE_CODE[2:0]] <= wd;
			if (ch_hit(a, A_SLEW))
				slew[a[2:0] - A_SLEW[2:0]] <= wd;
		end
	end

	// ----------------------------------------
	// module settings and coils
	// ----------------------------------------
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			node_addr   <= NODE_RST;
			line_set    <= LINE_RST;
			reply_delay <= 16'h0000;
			wdt_set     <= 16'h0000;
			proto       <= PROTO_RST;
			wdt_mode    <= 1'b0;
			wdt_en      <= 1'b0;
			fmt_eng     <= 1'b0;
		end else if (wr_take) begin
			unique case (a)
				A_NODE_ADDR:   node_addr <= wd;
				A_LINE: begin
					// unknown baud codes are refused, framing kept with them
					if (wd[BAUD_LSB +: BAUD_W] >= BAUD_MIN && wd[BAUD_LSB +: BAUD_W] <= BAUD_MAX)
						line_set <= {8'h00, wd[7:0]}; // [RL3]
				end
				A_REPLY_DELAY: reply_delay <= (wd > DELAY_MAX) ? DELAY_MAX : wd; // [RL4]
				A_WDT_SET:     wdt_set <= (wd > WDT_SET_MAX) ? WDT_SET_MAX : wd; // [RL5]
				A_PROTO:       proto <= wd[0]; // [RL7]
				A_WDT_MODE:    wdt_mode <= wd[0];
				A_WDT_EN:      wdt_en <= wd[0]; // [RL9]
				A_FORMAT:      fmt_eng <= wd[0]; // [RL10]
				default:       proto <= proto;
			endcase
		end
	end

	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST)
			first_read <= 1'b1;
		else if (rd_take && a == A_FIRST_READ)
			first_read <= 1'b0; // [RL13]
	end

	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST)
			O_CAL_RELOAD <= 1'b0;
		else
			O_CAL_RELOAD <= wr_take && a == A_CAL_RELOAD && wd[0]; // [RL12]
	end

	// ----------------------------------------
	// read decode
	// ----------------------------------------
	logic [15:0] next_rdata;
	logic        next_err;

	always_comb begin
		next_rdata = 16'h0000;
		next_err   = 1'b0;
		if (ch_hit(a, A_READBACK_I))
			next_rdata = ao[a[2:0] - A_READBACK_I[2:0]]; // [RL1]
		else if (ch_hit(a, A_READBACK_H))
			next_rdata = ao[a[2:0] - A_READBACK_H[2:0]]; // [RL1]
		else if (ch_hit(a, A_OUT_VALUE))
			next_rdata = ao[a[2:0] - A_OUT_VALUE[2:0]];
		else if (ch_hit(a, A_SAFE_VALUE))
			next_rdata = safe_v[a[2:0] - A_SAFE_VALUE[2:0]];
		else if (ch_hit(a, A_PWR_VALUE))
			next_rdata = pwr_v[a[2:0] - A_PWR_VALUE[2:0]];
		else if (ch_hit(a, A_TYPE_CODE))
			next_rdata = type_c[a[2:0] - A_TYPE_CODE[2:0]];
		else if (ch_hit(a, A_SLEW))
			next_rdata = slew[a[2:0] - A_SLEW[2:0]];
		else if (ch_hit(a, A_OPEN_WIRE))
			next_rdata = {15'h0000, open_wire[a[2:0] - A_OPEN_WIRE[2:0]]}; // [RL14]
		else if (ch_hit(a, A_OPEN_WIRE_D))
			next_rdata = {15'h0000, open_wire[a[2:0] - A_OPEN_WIRE_D[2:0]]}; // [RL14]
		else begin
			unique case (a)
				A_FW_LO:       next_rdata = FW_LO_ID;
				A_FW_HI:       next_rdata = FW_HI_ID;
				A_MODEL_LO:    next_rdata = MODEL_LO_ID;
				A_MODEL_HI:    next_rdata = MODEL_HI_ID;
				A_NODE_ADDR:   next_rdata = node_addr;
				A_LINE:        next_rdata = line_set;
				A_REPLY_DELAY: next_rdata = reply_delay;
				A_WDT_SET:     next_rdata = wdt_set;
				A_WDT_COUNT:   next_rdata = wdt_count;
				A_PROTO:       next_rdata = {15'h0000, proto};
				A_WDT_MODE:    next_rdata = {15'h0000, wdt_mode};
				A_WDT_EN:      next_rdata = {15'h0000, wdt_en};
				A_FORMAT:      next_rdata = {15'h0000, fmt_eng};
				A_WDT_FLAG:    next_rdata = {15'h0000, wdt_flag};
				A_CAL_RELOAD:  next_rdata = 16'h0000;
				A_FIRST_READ:  next_rdata = {15'h0000, first_read}; // [RL13]
				default:       next_err = 1'b1;
			endcase
		end
	end

	// ----------------------------------------
	// answer timing and indicator
	// ----------------------------------------
	logic [31:0] ms_div;
	logic [4:0]  ms_left;

	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			state       <= ST_IDLE;
			ms_div      <= 32'h0;
			ms_left     <= 5'h00;
			O_RSP_VALID <= 1'b0;
			O_RSP_RDATA <= 16'h0000;
			O_RSP_ERR   <= 1'b0;
		end else begin
			O_RSP_VALID <= 1'b0;
			unique case (state)
				ST_IDLE: begin
					if (take) begin
						state       <= ST_WAIT;
						ms_div      <= 32'h0;
						ms_left     <= reply_delay[4:0]; // [RL4]
						O_RSP_RDATA <= I_REQ_WR ? 16'h0000 : next_rdata;
						O_RSP_ERR   <= next_err;
					end
				end
				ST_WAIT: begin
					if (ms_left == 5'h00) begin
						state       <= ST_IDLE;
						O_RSP_VALID <= 1'b1;
					end else if (ms_div == 32'(MS_CYCLES - 1)) begin
						ms_div  <= 32'h0;
						ms_left <= ms_left - 5'h01;
					end else begin
						ms_div <= ms_div + 32'h1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST)
			O_PWR_LED <= 1'b1;
		else if (take)
			O_PWR_LED <= 1'b0; // [RL17]
		else if (state == ST_WAIT && ms_left == 5'h00)
			O_PWR_LED <= 1'b1; // [RL17]
	end

	// ----------------------------------------
	// effective link settings
	// ----------------------------------------
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			O_PROTO_MODBUS <= 1'b0;
			O_NODE_ADDR    <= NODE_RECOVERY;
			O_BAUD_CODE    <= BAUD_9600;
			O_FRAMING      <= FRAME_N1;
			O_FORMAT_ENG   <= 1'b0;
			O_WDT_FLAG     <= 1'b0;
			O_BUSY         <= 1'b1;
		end else begin
			O_FORMAT_ENG <= fmt_eng;
			O_WDT_FLAG   <= wdt_flag;
			O_BUSY       <= !init_done || state != ST_IDLE || take;
			if (recovery) begin
				O_PROTO_MODBUS <= 1'b0; // [RL18]
				O_NODE_ADDR    <= NODE_RECOVERY;
				O_BAUD_CODE    <= BAUD_9600;
				O_FRAMING      <= FRAME_N1;
			end else begin
				O_PROTO_MODBUS <= proto; // [RL7]
				O_NODE_ADDR    <= node_addr[7:0];
				O_BAUD_CODE    <= line_set[BAUD_LSB +: BAUD_W]; // [RL3]
				O_FRAMING      <= line_set[FRAME_LSB +: 2];
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ao
			assign O_AO_VALUE[g*16 +: 16] = ao[g];
		end
	endgenerate
endmodule : aom_regs
`default_nettype wire

// [verification/aom_regs_monitor.sv]
// concurrent checks on the register map ports
`timescale 1ns/100ps
`default_nettype none
module aom_regs_monitor
	import aom_pkg::*;
#(
	parameter int NUM_CH = 8
) (
	input wire logic                 I_CLK_SYS,
	input wire logic                 I_RST,
	input wire logic                 I_REQ_RD,
	input wire logic                 I_REQ_WR,
	input wire logic [15:0]          I_REQ_ADDR,
	input wire logic [15:0]          I_REQ_WDATA,
	input wire logic                 I_RECOVERY,
	input wire logic                 O_RSP_VALID,
	input wire logic [15:0]          O_RSP_RDATA,
	input wire logic                 O_BUSY,
	input wire logic [NUM_CH*16-1:0] O_AO_VALUE,
	input wire logic                 O_WDT_FLAG,
	input wire logic                 O_CAL_RELOAD,
	input wire logic                 O_PWR_LED,
	input wire logic                 O_PROTO_MODBUS,
	input wire logic [7:0]           O_NODE_ADDR,
	input wire logic [5:0]           O_BAUD_CODE,
	input wire logic [1:0]           O_FRAMING
);
	// ----------------------------------------
	// request port checks
	// ----------------------------------------
	// busy is registered, so a request present while it is low is taken
	logic take;
	assign take = (I_REQ_RD || I_REQ_WR) && !O_BUSY;
	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (I_RST);
	chk_led_off_take: assert property (take |=> !O_PWR_LED && O_BUSY)
		else $error("indicator not off after request");
	chk_led_on_answer: assert property (O_RSP_VALID |-> O_PWR_LED && !$past(O_PWR_LED))
		else $error("indicator not back on with answer");
	chk_answer_bound: assert property (take |-> ##[2:125] O_RSP_VALID)
		else $error("answer missing within delay limit");
	chk_answer_busy: assert property (O_RSP_VALID |-> O_BUSY ##1 (!O_BUSY && !O_RSP_VALID))
		else $error("answer strobe or busy malformed");
	chk_cal_pulse: assert property (take && I_REQ_WR && I_REQ_ADDR == A_CAL_RELOAD && I_REQ_WDATA[0]
		|=> O_CAL_RELOAD ##1 !O_CAL_RELOAD)
		else $error("calibration reload pulse wrong");
	chk_recovery_link: assert property (I_RECOVERY [*5] |=> !O_PROTO_MODBUS
		&& O_NODE_ADDR == NODE_RECOVERY && O_BAUD_CODE == BAUD_9600 && O_FRAMING == FRAME_N1)
		else $error("recovery link settings not applied");
	chk_flag_hold_ao: assert property (O_WDT_FLAG && $past(O_WDT_FLAG) |-> $stable(O_AO_VALUE))
		else $error("output changed while timed out");
	chk_readback_ch0: assert property (take && I_REQ_RD && !I_REQ_WR && I_REQ_ADDR == A_READBACK_I
		|=> O_RSP_RDATA == $past(O_AO_VALUE[15:0]))
		else $error("readback differs from output");
endmodule : aom_regs_monitor
bind aom_regs aom_regs_monitor #(.NUM_CH(NUM_CH)) u_monitor (
	.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_REQ_RD(I_REQ_RD), .I_REQ_WR(I_REQ_WR),
	.I_REQ_ADDR(I_REQ_ADDR), .I_REQ_WDATA(I_REQ_WDATA), .I_RECOVERY(I_RECOVERY),
	.O_RSP_VALID(O_RSP_VALID), .O_RSP_RDATA(O_RSP_RDATA), .O_BUSY(O_BUSY), .O_AO_VALUE(O_AO_VALUE),
	.O_WDT_FLAG(O_WDT_FLAG), .O_CAL_RELOAD(O_CAL_RELOAD), .O_PWR_LED(O_PWR_LED),
	.O_PROTO_MODBUS(O_PROTO_MODBUS), .O_NODE_ADDR(O_NODE_ADDR), .O_BAUD_CODE(O_BAUD_CODE),
	.O_FRAMING(O_FRAMING)
);
`default_nettype wire

// [verification/aom_host_model.sv]
// host model that issues requests on the register port
`timescale 1ns/100ps
`default_nettype none
module aom_host_model (
	input  wire logic        i_clk,
	input  wire logic        i_rsp_valid,
	input  wire logic [15:0] i_rsp_rdata,
	input  wire logic        i_rsp_err,
	output logic             o_rd,
	output logic             o_wr,
	output logic [15:0]      o_addr,
	output logic [15:0]      o_wdata
);
	initial begin
		o_rd = 1'h0;
		o_wr = 1'h0;
		o_addr = 16'h0;
		o_wdata = 16'h0;
	end
	// one request outstanding, held until the answer strobe is sampled
	task automatic xfer(input logic wr, input logic [15:0] addr, input logic [15:0] wdata,
		output logic [15:0] rdata, output logic err, output int n);
		@(posedge i_clk);
		o_rd <= !wr;
		o_wr <= wr;
		o_addr <= addr;
		o_wdata <= wdata;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (i_rsp_valid !== 1'h1 && n < 200);
		rdata = (n < 200) ? i_rsp_rdata : 16'hXXXX;
		err = i_rsp_err;
		// released address and data lines show the inverse so stale values never pass for live ones
		o_rd <= 1'h0;
		o_wr <= 1'h0;
		o_addr <= ~addr;
		o_wdata <= ~wdata;
	endtask : xfer
endmodule : aom_host_model
`default_nettype wire

// [verification/testbench.sv]
// self-checking testbench of the register map
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import aom_pkg::*;
	localparam int MSC = 4;
	localparam logic R = 1'h0;
	localparam logic W = 1'h1;
	typedef struct packed {
		logic        wr;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic [15:0] exp;
		logic        err;
	} aom_row_t;
	logic         clk = 1'h0;
	logic         rst = 1'h1;
	logic         rec = 1'h0;
	logic [7:0]   ow = 8'h05;
	logic         nv = 1'h0;
	logic         req_rd, req_wr, rsp_valid, rsp_err, busy, flag, led, proto, fmt;
	logic [15:0]  req_addr, req_wdata, rsp_rdata, rd_q;
	logic [127:0] ao;
	logic [7:0]   node;
	logic [5:0]   baud;
	logic [1:0]   frm;
	logic         rd_err;
	int           rd_n;
	int           num_errors = 0;
	int           n_tests = 0;
	int           dl [3] = '{30, 3, 0};
	localparam int NR = 26;
	aom_row_t rows [NR] = '{
		'{R, A_FIRST_READ, 16'h0, 16'h1, 1'h0},
		'{R, A_FIRST_READ, 16'h0, 16'h0, 1'h0},
		'{R, A_PROTO, 16'h0, 16'h1, 1'h0},
		'{R, A_MODEL_LO, 16'h0, MODEL_LO_ID, 1'h0},
		'{R, A_OPEN_WIRE, 16'h0, 16'h1, 1'h0},
		'{R, A_OPEN_WIRE + 16'h1, 16'h0, 16'h0, 1'h0},
		'{R, A_OPEN_WIRE_D + 16'h2, 16'h0, 16'h1, 1'h0},
		'{W, A_OUT_VALUE, 16'h8000, 16'h0, 1'h0},
		'{R, A_READBACK_I, 16'h0, 16'h8000, 1'h0},
		'{W, A_OUT_VALUE + 16'h7, 16'h7FFF, 16'h0, 1'h0},
		'{R, A_READBACK_H + 16'h7, 16'h0, 16'h7FFF, 1'h0},
		'{W, A_REPLY_DELAY, 16'h1F, 16'h0, 1'h0},
		'{R, A_REPLY_DELAY, 16'h0, 16'h1E, 1'h0},
		'{W, A_WDT_SET, 16'h100, 16'h0, 1'h0},
		'{R, A_WDT_SET, 16'h0, 16'hFF, 1'h0},
		'{R, 16'h1234, 16'h0, 16'h0, 1'h1},
		'{W, A_CAL_RELOAD, 16'h1, 16'h0, 1'h0},
		'{W, A_FORMAT, 16'h1, 16'h0, 1'h0},
		'{W, A_TYPE_CODE + 16'h1, 16'h1, 16'h0, 1'h0},
		'{W, A_OUT_VALUE + 16'h1, 16'h64, 16'h0, 1'h0},
		'{R, A_READBACK_I + 16'h1, 16'h0, 16'hFA0, 1'h0},
		'{W, A_OUT_VALUE + 16'h1, 16'h7530, 16'h0, 1'h0},
		'{R, A_READBACK_I + 16'h1, 16'h0, 16'h4E20, 1'h0},
		'{W, A_FORMAT, 16'h0, 16'h0, 1'h0},
		'{W, A_OUT_VALUE + 16'h1, 16'h64, 16'h0, 1'h0},
		'{R, A_OUT_VALUE + 16'h1, 16'h0, 16'h64, 1'h0}
	};
	always #25 clk = ~clk;
	aom_regs #(.NUM_CH(8), .MS_CYCLES(MSC), .WDT_CYCLES(10)) DUT (
		.I_CLK_SYS     (clk),
		.I_RST         (rst),
		.I_REQ_RD      (req_rd),
		.I_REQ_WR      (req_wr),
		.I_REQ_ADDR    (req_addr),
		.I_REQ_WDATA   (req_wdata),
		.I_RECOVERY    (rec),
		.I_OPEN_WIRE   (ow),
		.I_WDT_FLAG_NV (nv),
		.O_RSP_VALID   (rsp_valid),
		.O_RSP_RDATA   (rsp_rdata),
		.O_RSP_ERR     (rsp_err),
		.O_BUSY        (busy),
		.O_AO_VALUE    (ao),
		.O_WDT_FLAG    (flag),
		.O_CAL_RELOAD  (),
		.O_PWR_LED     (led),
		.O_PROTO_MODBUS(proto),
		.O_NODE_ADDR   (node),
		.O_BAUD_CODE   (baud),
		.O_FRAMING     (frm),
		.O_FORMAT_ENG  (fmt)
	);
	aom_host_model u_host (
		.i_clk      (clk),
		.i_rsp_valid(rsp_valid),
		.i_rsp_rdata(rsp_rdata),
		.i_rsp_err  (rsp_err),
		.o_rd       (req_rd),
		.o_wr       (req_wr),
		.o_addr     (req_addr),
		.o_wdata    (req_wdata)
	);
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic rw(input logic wr, input logic [15:0] a, input logic [15:0] d);
		u_host.xfer(wr, a, d, rd_q, rd_err, rd_n);
		@(negedge clk);
	endtask : rw
	task automatic do_reset(input logic f);
		@(posedge clk);
		rst <= 1'h1;
		nv <= f;
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		// init runs four edges and busy drops one edge later, so requests are taken from the sixth
		repeat (6) @(posedge clk);
		@(negedge clk);
	endtask : do_reset
	task automatic wait_flag;
		int n;
		n = 0;
		while (flag !== 1'h1 && n < 60) begin
			@(negedge clk);
			n++;
		end
		cmp({15'h0, flag}, 16'h1);
	endtask : wait_flag
	task finish_test;
		if (num_errors == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		finish_test;
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		do_reset(1'h0);
		cmp({7'h0, proto, node}, 16'h0101);
		cmp({8'h0, frm, baud}, {8'h0, FRAME_N1, BAUD_9600});
		cmp(ao[15:0], 16'h0);
		for (int i = 0; i < NR; i++) begin
			rw(rows[i].wr, rows[i].addr, rows[i].wdata);
			cmp(rd_q, rows[i].exp);
			cmp({15'h0, rd_err}, {15'h0, rows[i].err});
		end
		rw(W, A_FORMAT, 16'h1);
		cmp({15'h0, fmt}, 16'h1);
		for (int b = 3; b <= 10; b++) begin
			rw(W, A_LINE, 16'(b + (b % 4) * 64));
			cmp({8'h0, frm, baud}, {8'h0, 2'(b % 4), 6'(b)});
		end
		rw(W, A_LINE, 16'h000B);
		rw(W, A_LINE, 16'h0042);
		rw(R, A_LINE, 16'h0);
		cmp(rd_q, 16'h008A);
		foreach (dl[k]) begin
			rw(W, A_REPLY_DELAY, 16'(dl[k]));
			rw(R, A_NODE_ADDR, 16'h0);
			cmp(16'(rd_n), 16'(3 + dl[k] * MSC));
		end
		@(posedge clk);
		rec <= 1'h1;
		repeat (8) @(posedge clk);
		rw(R, A_NODE_ADDR, 16'h0);
		cmp(rd_q, 16'h1);
		cmp({7'h0, proto, node}, {8'h0, NODE_RECOVERY});
		cmp({10'h0, baud}, {10'h0, BAUD_9600});
		@(posedge clk);
		rec <= 1'h0;
		rw(W, A_SAFE_VALUE, 16'h1111);
		rw(W, A_WDT_SET, 16'h3);
		rw(W, A_WDT_EN, 16'h1);
		// steady polling keeps the host watchdog from expiring
		for (int k = 0; k < 20; k++) rw(R, A_WDT_FLAG, 16'h0);
		cmp({15'h0, flag}, 16'h0);
		wait_flag;
		cmp(ao[15:0], 16'h1111);
		rw(W, A_OUT_VALUE, 16'h2222);
		cmp(ao[15:0], 16'h1111);
		rw(R, A_WDT_COUNT, 16'h0);
		cmp(rd_q, 16'h1);
		rw(W, A_WDT_COUNT, 16'h0);
		rw(R, A_WDT_COUNT, 16'h0);
		cmp(rd_q, 16'h0);
		rw(R, A_WDT_FLAG, 16'h0);
		cmp(rd_q, 16'h1);
		rw(W, A_WDT_FLAG, 16'h1);
		rw(W, A_OUT_VALUE, 16'h2222);
		cmp(ao[15:0], 16'h2222);
		rw(W, A_WDT_MODE, 16'h1);
		wait_flag;
		rw(W, A_OUT_VALUE, 16'h3333);
		cmp({15'h0, flag}, 16'h0);
		cmp(ao[15:0], 16'h1111);
		rw(W, A_WDT_EN, 16'h0);
		repeat (50) @(negedge clk);
		cmp({15'h0, flag}, 16'h0);
		do_reset(1'h1);
		cmp({15'h0, flag}, 16'h1);
		cmp(ao[15:0], 16'h0);
		rw(R, A_FIRST_READ, 16'h0);
		cmp(rd_q, 16'h1);
		finish_test;
	end
endmodule : testbench
`default_nettype wire
